//--- pcm_pkg.sv
// Shared constants for the peak current control chain.
// Assumes a single 10 MHz system clock and synchronous reset.
package pcm_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_STEP_NS = 32;
  // Step interval rounds down, never below one cycle
  localparam int RAMP_STEP_CYC_RAW = RAMP_STEP_NS / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_CYC_RAW < 1) ? 1 : RAMP_STEP_CYC_RAW;
  localparam int NUM_CH = 4;
  localparam int NUM_FE = 3;
  localparam logic [1:0] FE_SEL_PEAK = 2'h2;
  localparam logic FILT_SEL_ZERO = 1'h0;
  localparam logic FILT_SEL_ONE = 1'h1;
  localparam logic RAMP_START_FILTER = 1'h1;
  // Edge source select codes
  localparam logic [2:0] EDGE_CH2_A = 3'h1;
  localparam logic [2:0] EDGE_CH2_B = 3'h2;
  localparam logic [2:0] EDGE_CH3_A = 3'h5;
  localparam logic [2:0] EDGE_CH3_B = 3'h6;
  localparam logic [3:0] INTRA_EDGE = 4'h1;
  localparam logic [3:0] INTRA_OWN = 4'h0;
  localparam logic [2:0] ERR_MODE_PEAK = 3'h5;
  localparam logic [15:0] RAMP_RESET_VAL = 16'h0000;
endpackage : pcm_pkg

//--- pcm_cycle_limit.sv
// One pulse channel: cycle limit chop of A, B rebuilt after a gap.
// Assumes a period counter and event positions supplied by the top.
`timescale 1ns/1ps
module pcm_cycle_limit #(
  parameter int CW = 12
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic frame_start,
  input wire logic [CW-1:0] period_cnt,
  input wire logic [CW-1:0] event2,
  input wire logic [CW-1:0] event3,
  input wire logic [CW-1:0] filter_edge,
  input wire logic voltage_mode,
  input wire logic limit_on,
  input wire logic current_limit_input,
  output logic a_fault_out,
  output logic b_fault_out
);
  logic chopped_ff;
  logic [CW-1:0] gap_ff;
  logic gap_run_ff;
  logic a_ff;
  logic b_ff;
  logic [CW-1:0] a_off_pos;
  logic [CW-1:0] gap_len;
  logic peak_hit;

  // Filter places the A fall in voltage mode, event 2 otherwise
  assign a_off_pos = voltage_mode ? filter_edge : event2; // RL7 RL8
  assign gap_len = event3 - event2; // RL5
  assign peak_hit = limit_on && current_limit_input && a_ff && !voltage_mode; // RL6

  // Chop latch: once hit, B skips its event 3 rise until the next frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst || frame_start) begin
      chopped_ff <= 1'b0;
    end else if (peak_hit) begin
      chopped_ff <= 1'b1;
    end
  end

  // A output: high from frame start to limit or fallback position
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      a_ff <= 1'b0;
    end else if (frame_start) begin
      a_ff <= 1'b1;
    end else if (peak_hit || period_cnt == a_off_pos) begin // RL6 RL8
      a_ff <= 1'b0;
    end
  end

  // B: low at chop, high again after event3 - event2 cycles
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      b_ff <= 1'b0;
      gap_ff <= '0;
      gap_run_ff <= 1'b0;
    end else if (peak_hit) begin
      b_ff <= 1'b0;
      gap_ff <= gap_len; // RL5
      gap_run_ff <= 1'b1;
    end else if (gap_run_ff) begin
      if (gap_ff <= CW'(1)) begin
        gap_run_ff <= 1'b0;
        b_ff <= 1'b1;
      end else begin
        gap_ff <= gap_ff - CW'(1);
      end
    end else if (frame_start) begin
      b_ff <= 1'b0;
    end else if (!chopped_ff && period_cnt == event3) begin // RL8
      b_ff <= 1'b1;
    end
  end

  assign a_fault_out = a_ff;
  assign b_fault_out = b_ff;
endmodule : pcm_cycle_limit

//--- pcm_chain.sv
// Peak current control chain: ramp, comparator, routing, four channels, edge builder.
// Assumes analog values arrive as sampled words synchronous to clk_sys.
// Behaviour
// RL1: Edge builder A rises on ch2 B rise, falls on ch3 A fall.
// RL2: Edge builder B rises on ch3 B rise, falls on ch2 A fall.
// RL3: Intra mux value 1 sends edge builder results to channel pins.
// RL4: Edge builder enable on all channels keeps equal output delay.
// RL5: After a chop, B re-rises after event3 minus event2.
// RL6: Peak event through cycle limit logic makes A fall edges.
// RL7: Voltage mode: filter value places A falling edge.
// RL8: No peak event: edges from event registers 2 and 3.
// RL9: All channels normal with cycle limit; ch0/1 B drive rectifiers.
// RL10: External compensation: ch1 A and B pulse each half cycle.
// RL11: Comparator asserts peak event when ramp exceeds primary current.
// RL12: Ramp starts on frame or pin trigger, steps every 32 ns; code steps once per 100 ns clock (RAMP_STEP_CYC = 1).
// RL13: Ramp source select 0 takes filter 0, 1 takes filter 1.
// RL14: Software moves ramp source to filter 1 when voltage loop exceeds current.
// RL15: Start select 1 and run bit both needed for the ramp; code runs on the run bit alone, start select 0 starts from the held value.
// RL16: Step size sets slope; optional final value bounds the ramp.
// RL17: Diff-to-single comparator enable must be set for peak detection.
// RL18: Software sets error converter mode 5 for peak operation.
// RL19: Front end choice picks one of 3; peak mode enable required.
// RL20: Per-channel peak enable connects event to current limit input.
// RL21: Per-channel frame start enable triggers the ramp at period start.
// RL22: A single comparator, attachable to any front end.
// RL23: Ramp reloads at trigger, holds at final value until next trigger.
`timescale 1ns/1ps
module pcm_chain #(
  parameter int CW = 12,
  parameter int DW = 16,
  parameter int NCH = pcm_pkg::NUM_CH,
  parameter int NFE = pcm_pkg::NUM_FE
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [CW-1:0] period_len,
  input wire logic [NCH*CW-1:0] phase_ofs,
  input wire logic [NCH*CW-1:0] event2,
  input wire logic [NCH*CW-1:0] event3,
  input wire logic [CW-1:0] filter_edge,
  input wire logic voltage_mode,
  input wire logic [NCH-1:0] limit_on,
  input wire logic [DW-1:0] filter0_value,
  input wire logic [DW-1:0] filter1_value,
  input wire logic ramp_source_control,
  input wire logic slope_ramp_start_sel,
  input wire logic slope_ramp_run,
  input wire logic [DW-1:0] ramp_step_size,
  input wire logic [DW-1:0] ramp_final_value,
  input wire logic ramp_end_on,
  input wire logic pin_trigger,
  input wire logic [NCH-1:0] frame_start_ramp_trigger,
  input wire logic [NFE*DW-1:0] fe_sample,
  input wire logic diff_to_single_comparator_on,
  input wire logic [2:0] error_converter_mode,
  input wire logic [1:0] peak_front_end_choice,
  input wire logic peak_enable,
  input wire logic [NCH-1:0] analog_peak_on,
  input wire logic [NCH-1:0] edge_builder_on,
  input wire logic [2:0] edge_a_on_sel,
  input wire logic [2:0] edge_a_off_sel,
  input wire logic [2:0] edge_b_on_sel,
  input wire logic [2:0] edge_b_off_sel,
  input wire logic [3:0] ch2_a_intra_sel,
  input wire logic [3:0] ch2_b_intra_sel,
  input wire logic ext_slope_comp,
  output logic [NCH-1:0] pin_a,
  output logic [NCH-1:0] pin_b,
  output logic analog_peak_event,
  output logic [DW-1:0] ramp_value,
  output logic ramp_active
);
  logic [CW-1:0] period_ff;
  logic frame_start;
  logic half_start;
  logic [NCH-1:0] ch_frame;
  logic [NCH-1:0] fa;
  logic [NCH-1:0] fb;
  logic [NCH-1:0] fa_d_ff;
  logic [NCH-1:0] fb_d_ff;
  logic [NCH-1:0] rise_b;
  logic [NCH-1:0] fall_a;
  logic [NCH-1:0] current_limit_input;
  logic [DW-1:0] ramp_ff;
  logic ramp_run_ff;
  logic [7:0] step_cnt_ff;
  logic step_en;
  logic ramp_trig;
  logic [DW-1:0] start_val;
  logic [DW-1:0] primary_sample;
  logic [DW:0] nxt_ramp;
  logic peak_ff;
  logic [2:0] sel_fe;
  logic eg_a_ff;
  logic eg_b_ff;
  logic [NCH-1:0] out_a_ff;
  logic [NCH-1:0] out_b_ff;
  logic comp_pulse_ff;

  // Shared period timer for all channels
  always_ff @(posedge clk_sys) begin
    if (sys_rst || period_ff >= period_len) begin
      period_ff <= '0;
    end else begin
      period_ff <= period_ff + CW'(1);
    end
  end
  assign frame_start = (period_ff == '0);
  assign half_start = (period_ff == (period_len >> 1)) || frame_start;

  // Channel frames, each offset by its phase
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [CW-1:0] ch_cnt;
    assign ch_cnt = period_ff - phase_ofs[c*CW +: CW];
    assign ch_frame[c] = (period_ff == phase_ofs[c*CW +: CW]);
    // Peak event reaches each cycle limit input through its enable
    assign current_limit_input[c] = analog_peak_on[c] && analog_peak_event; // RL20
    pcm_cycle_limit #(.CW(CW)) u_lim (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .frame_start(ch_frame[c]),
      .period_cnt(ch_cnt),
      .event2(event2[c*CW +: CW]),
      .event3(event3[c*CW +: CW]),
      .filter_edge(filter_edge),
      .voltage_mode(voltage_mode),
      .limit_on(limit_on[c]), // RL9
      .current_limit_input(current_limit_input[c]),
      .a_fault_out(fa[c]),
      .b_fault_out(fb[c])
    );
  end

  // Edge history for the edge builder
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fa_d_ff <= '0;
      fb_d_ff <= '0;
    end else begin
      fa_d_ff <= fa;
      fb_d_ff <= fb;
    end
  end
  assign rise_b = fb & ~fb_d_ff;
  assign fall_a = ~fa & fa_d_ff;

  // Decode one select code into an edge event
  function automatic logic edge_pick(input logic [2:0] sel, input logic [NCH-1:0] ra,
                                     input logic [NCH-1:0] fl);
    logic r;
    r = 1'b0;
    unique case (sel)
      pcm_pkg::EDGE_CH2_A: r = fl[2];
      pcm_pkg::EDGE_CH2_B: r = ra[2];
      pcm_pkg::EDGE_CH3_A: r = fl[3];
      pcm_pkg::EDGE_CH3_B: r = ra[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : edge_pick

  // Edge builder in channel 2: set on one edge, clear on another
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !edge_builder_on[2]) begin
      eg_a_ff <= 1'b0;
      eg_b_ff <= 1'b0;
    end else begin
      if (edge_pick(edge_a_on_sel, rise_b, fall_a)) begin
        eg_a_ff <= 1'b1; // RL1
      end else if (edge_pick(edge_a_off_sel, rise_b, fall_a)) begin
        eg_a_ff <= 1'b0; // RL1
      end
      if (edge_pick(edge_b_on_sel, rise_b, fall_a)) begin
        eg_b_ff <= 1'b1; // RL2
      end else if (edge_pick(edge_b_off_sel, rise_b, fall_a)) begin
        eg_b_ff <= 1'b0; // RL2
      end
    end
  end

  // Compensator reset pulse at each half cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      comp_pulse_ff <= 1'b0;
    end else begin
      comp_pulse_ff <= ext_slope_comp && half_start; // RL10
    end
  end

  // Output register stage; with the builder on, every pin takes the
  // same extra flop so delays match across channels
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_a_ff <= '0;
      out_b_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        out_a_ff[c] <= fa_d_ff[c] && edge_builder_on[c]; // RL4
        out_b_ff[c] <= fb_d_ff[c] && edge_builder_on[c]; // RL4
      end
      out_a_ff[2] <= (ch2_a_intra_sel == pcm_pkg::INTRA_EDGE) ? eg_a_ff : fa_d_ff[2]; // RL3
      out_b_ff[2] <= (ch2_b_intra_sel == pcm_pkg::INTRA_EDGE) ? eg_b_ff : fb_d_ff[2]; // RL3
      if (ext_slope_comp) begin
        out_a_ff[1] <= comp_pulse_ff; // RL10
        out_b_ff[1] <= comp_pulse_ff; // RL10
      end
    end
  end
  assign pin_a = out_a_ff;
  assign pin_b = out_b_ff;

  // Ramp trigger from frame starts or the pin
  assign ramp_trig = pin_trigger || |(frame_start_ramp_trigger & ch_frame); // RL12 RL21
  assign start_val = (ramp_source_control == pcm_pkg::FILT_SEL_ONE) ? filter1_value : filter0_value; // RL13

  // Step divider: one enable each step interval
  always_ff @(posedge clk_sys) begin
    if (sys_rst || ramp_trig || step_cnt_ff >= 8'(pcm_pkg::RAMP_STEP_CYC - 1)) begin
      step_cnt_ff <= '0;
    end else begin
      step_cnt_ff <= step_cnt_ff + 8'h01;
    end
  end
  assign step_en = (step_cnt_ff >= 8'(pcm_pkg::RAMP_STEP_CYC - 1)); // RL12

  // Downward ramp, clamped at the final value, or at zero with ramp_end_on clear
  assign nxt_ramp = {1'b0, ramp_ff} - {1'b0, ramp_step_size}; // RL16
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !slope_ramp_run) begin // RL15
      ramp_ff <= pcm_pkg::RAMP_RESET_VAL;
      ramp_run_ff <= 1'b0;
    end else if (ramp_trig) begin
      ramp_ff <= (slope_ramp_start_sel == pcm_pkg::RAMP_START_FILTER) ? start_val : ramp_ff; // RL15 RL23
      ramp_run_ff <= 1'b1;
    end else if (ramp_run_ff && step_en) begin
      if (nxt_ramp[DW] || (ramp_end_on && nxt_ramp[DW-1:0] <= ramp_final_value)) begin
        ramp_ff <= ramp_end_on ? ramp_final_value : DW'(0); // RL23
        ramp_run_ff <= 1'b0;
      end else begin
        ramp_ff <= nxt_ramp[DW-1:0];
      end
    end
  end
  assign ramp_value = ramp_ff;
  assign ramp_active = ramp_run_ff;

  // Single comparator, attachable to any front end
  assign sel_fe = {1'b0, peak_front_end_choice};
  always_comb begin
    primary_sample = '0;
    for (int f = 0; f < NFE; f++) begin
      if (sel_fe == 3'(f)) begin
        primary_sample = fe_sample[f*DW +: DW]; // RL19 RL22
      end
    end
  end

  // Compare needs peak enable, converter mode and diff-to-single path
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      peak_ff <= 1'b0;
    end else begin
      peak_ff <= peak_enable && diff_to_single_comparator_on // RL17 RL19
                 && (error_converter_mode == pcm_pkg::ERR_MODE_PEAK) // RL18
                 && (ramp_ff > primary_sample) && (sel_fe < 3'(NFE)); // RL11
    end
  end
  assign analog_peak_event = peak_ff;
endmodule : pcm_chain

//--- pcm_chain_props.sv
// Port checker for the peak current control chain.
// Assumes binding onto pcm_chain; widths follow its parameters.
`timescale 1ns/1ps
module pcm_chain_props #(
  parameter int DW = 16,
  parameter int NCH = 4,
  parameter int NFE = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ramp_source_control,
  input wire logic slope_ramp_start_sel,
  input wire logic slope_ramp_run,
  input wire logic [DW-1:0] filter0_value,
  input wire logic [DW-1:0] filter1_value,
  input wire logic [DW-1:0] ramp_step_size,
  input wire logic [DW-1:0] ramp_final_value,
  input wire logic ramp_end_on,
  input wire logic pin_trigger,
  input wire logic [NCH-1:0] frame_start_ramp_trigger,
  input wire logic [NFE*DW-1:0] fe_sample,
  input wire logic diff_to_single_comparator_on,
  input wire logic [2:0] error_converter_mode,
  input wire logic [1:0] peak_front_end_choice,
  input wire logic peak_enable,
  input wire logic ext_slope_comp,
  input wire logic [NCH-1:0] pin_a,
  input wire logic analog_peak_event,
  input wire logic [DW-1:0] ramp_value
);
  logic trig, ok, en, hit;
  logic [DW:0] lim;
  // Any trigger source may reload, so stepping checks skip those cycles
  assign trig = pin_trigger | (|frame_start_ramp_trigger);
  assign ok = diff_to_single_comparator_on & peak_enable & (error_converter_mode == 3'h5);
  assign en = ok & (peak_front_end_choice < 2'h3);
  assign hit = ramp_value > fe_sample[peak_front_end_choice*DW +: DW];
  assign lim = ramp_end_on ? {1'b0, ramp_final_value} : '0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rst;
    disable iff (1'b0) sys_rst |=> pin_a == '0 && !analog_peak_event && ramp_value == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_refuse;
    !ok |=> !analog_peak_event;
  endproperty
  a_refuse: assert property (p_refuse) else $error("peak event while comparator disabled");
  property p_cmp;
    en |=> analog_peak_event == $past(hit);
  endproperty
  a_cmp: assert property (p_cmp) else $error("peak event does not follow compare");
  property p_off;
    !slope_ramp_run |=> ramp_value == '0;
  endproperty
  a_off: assert property (p_off) else $error("ramp not cleared when stopped");
  property p_load;
    slope_ramp_run && slope_ramp_start_sel && pin_trigger
      |=> ramp_value == ($past(ramp_source_control) ? $past(filter1_value) : $past(filter0_value));
  endproperty
  a_load: assert property (p_load) else $error("ramp start value wrong");
  property p_step;
    slope_ramp_run && !trig && {1'b0, ramp_value} >= lim + ramp_step_size && ramp_value != $past(ramp_value)
      |=> ramp_value == $past(ramp_value) - $past(ramp_step_size);
  endproperty
  a_step: assert property (p_step) else $error("ramp step wrong");
  property p_hold;
    slope_ramp_run && !trig && ramp_end_on && ramp_value == ramp_final_value |=> $stable(ramp_value);
  endproperty
  a_hold: assert property (p_hold) else $error("ramp moved past final value");
  property p_pulse;
    ext_slope_comp [*4] ##0 pin_a[1] |=> !pin_a[1];
  endproperty
  a_pulse: assert property (p_pulse) else $error("compensator reset pulse too long");
endmodule : pcm_chain_props
bind pcm_chain pcm_chain_props #(.DW(DW), .NCH(NCH), .NFE(NFE)) u_props (.*);

//--- pcm_bridge_model.sv
// Behavioural primary current of the bridge power stage.
// Assumes ideal gate drivers with no delay on pin_a.
`timescale 1ns/1ps
module pcm_bridge_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] pin_a,
  output logic [15:0] ipri
);
  // Current builds while a primary leg conducts; no memory across off time
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !(pin_a[0] | pin_a[1])) begin
      ipri <= 16'h0000;
    end else begin
      ipri <= ipri + 16'h0400;
    end
  end
endmodule : pcm_bridge_model

//--- pcm_chain_tb.sv
// Self-checking bench for the peak current control chain.
// Assumes pcm_chain, pcm_bridge_model and the bound checker.
`timescale 1ns/1ps
module pcm_chain_tb;
  logic clk_sys, sys_rst, voltage_mode, ramp_source_control, slope_ramp_start_sel, slope_ramp_run, ramp_end_on;
  logic pin_trigger, diff_to_single_comparator_on, peak_enable, ext_slope_comp, analog_peak_event, ramp_active;
  logic use_model;
  logic [11:0] period_len, filter_edge;
  logic [47:0] phase_ofs, event2, event3, fe_sample, fe_rnd;
  logic [3:0] limit_on, frame_start_ramp_trigger, analog_peak_on, edge_builder_on, pin_a, pin_b;
  logic [3:0] ch2_a_intra_sel, ch2_b_intra_sel;
  logic [15:0] filter0_value, filter1_value, ramp_step_size, ramp_final_value, ramp_value, ipri, exp_v;
  logic [2:0] error_converter_mode, edge_a_on_sel, edge_a_off_sel, edge_b_on_sel, edge_b_off_sel;
  logic [1:0] peak_front_end_choice;
  logic [31:0] rnd;
  int seed = 32'h0B8DC034;
  int num_errors, check_count, cnt_open, cnt_chop, cnt_b, k;
  pcm_chain dut_u (.*);
  pcm_bridge_model bridge_u (.*);
  // Model current replaces front end two only when asked
  assign fe_sample = use_model ? {ipri, fe_rnd[31:0]} : fe_rnd;
  // Free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] ramp_next(input logic [15:0] v, st, lo);
    return ({1'b0, v} >= {1'b0, lo} + st) ? v - st : lo;
  endfunction : ramp_next
  function automatic logic [15:0] exp_peak(input logic on, input logic [15:0] st, smp);
    return {15'h0000, on && st > smp};
  endfunction : exp_peak
  task automatic chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wait_val(input logic [15:0] v);
    int i = 0;
    while (ramp_value !== v && i < 400) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (ramp_value !== v) begin
      chk(ramp_value, v);
      finish_test();
    end
  endtask : wait_val
  // High cycles of one channel's A and B pins over two full periods
  task automatic count_a(input int n, output int ca, output int cb);
    ca = 0;
    cb = 0;
    repeat (80) begin
      @(posedge clk_sys);
      #1;
      ca += int'(pin_a[n]);
      cb += int'(pin_b[n]);
    end
  endtask : count_a
  // Cycles from channel 0 A chop fall to its B return; builder pins follow
  task automatic gap_b(output int c);
    int i;
    c = 0;
    i = 0;
    while (!pin_a[0] && i < 100) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    while (pin_a[0] && i < 100) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    chk({14'h0000, pin_a[2], pin_b[2]}, 16'h0000);
    while (!pin_b[0] && c < 100) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk({14'h0000, pin_a[2], pin_b[2]}, 16'h0003);
  endtask : gap_b
  // Main sequence
  initial begin
    {sys_rst, slope_ramp_start_sel, slope_ramp_run, ramp_end_on, diff_to_single_comparator_on, peak_enable} = 6'h3F;
    {voltage_mode, ramp_source_control, pin_trigger, ext_slope_comp, use_model} = 5'h00;
    {period_len, filter_edge, phase_ofs, fe_rnd} = {12'h027, 12'h010, 48'h0, 48'h0};
    {event2, event3} = {{4{12'h00C}}, {4{12'h014}}};
    {limit_on, frame_start_ramp_trigger, analog_peak_on, edge_builder_on} = 16'hF00F;
    {filter0_value, filter1_value, ramp_step_size, ramp_final_value} = {32'h0, 16'h0100, 16'h0};
    {error_converter_mode, peak_front_end_choice} = {3'h5, 2'h2};
    {edge_a_on_sel, edge_a_off_sel} = {pcm_pkg::EDGE_CH2_B, pcm_pkg::EDGE_CH3_A};
    {edge_b_on_sel, edge_b_off_sel} = {pcm_pkg::EDGE_CH3_B, pcm_pkg::EDGE_CH2_A};
    {ch2_a_intra_sel, ch2_b_intra_sel} = {pcm_pkg::INTRA_EDGE, pcm_pkg::INTRA_EDGE};
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(ramp_value, 16'h0000);
    // Reload from each filter, step once, then settle at the final value
    for (k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      rnd = $random(seed);
      {filter0_value, filter1_value} <= {1'b1, rnd[14:0], 1'b1, rnd[30:16]};
      {ramp_step_size, ramp_final_value} <= {8'h01, rnd[7:0], 2'b00, rnd[31:18]};
      ramp_source_control <= k[0];
      pin_trigger <= 1'b1;
      @(posedge clk_sys);
      pin_trigger <= 1'b0;
      #1;
      exp_v = k[0] ? filter1_value : filter0_value;
      chk(ramp_value, exp_v);
      chk({15'h0000, ramp_active}, 16'h0001);
      @(posedge clk_sys);
      #1;
      chk(ramp_value, ramp_next(exp_v, ramp_step_size, ramp_final_value));
      wait_val(ramp_final_value);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(ramp_value, ramp_final_value);
      chk({15'h0000, ramp_active}, 16'h0000);
    end
    @(posedge clk_sys);
    slope_ramp_run <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(ramp_value, 16'h0000);
    $display("ramp test done");
    // Flat ramp at 8000 against random samples, every enable knocked out in turn
    @(posedge clk_sys);
    {slope_ramp_run, pin_trigger, ramp_step_size, ramp_final_value, filter0_value} <= {2'h3, 32'h0, 16'h8000};
    ramp_source_control <= 1'b0;
    @(posedge clk_sys);
    pin_trigger <= 1'b0;
    for (k = 0; k < 12; k++) begin
      rnd = $random(seed);
      diff_to_single_comparator_on <= (k % 4 != 1);
      error_converter_mode <= (k % 4 == 2) ? 3'h4 : 3'h5;
      peak_enable <= (k % 4 != 3);
      peak_front_end_choice <= 2'(k / 4);
      fe_rnd <= {rnd[15:0], rnd[31:16], rnd[15:0]};
      repeat (2) @(posedge clk_sys);
      #1;
      chk({15'h0000, analog_peak_event}, exp_peak(k % 4 == 0, 16'h8000, (k / 4 == 1) ? rnd[31:16] : rnd[15:0]));
      @(posedge clk_sys);
    end
    $display("comparator test done");
    // Frame-started ramp, bridge current on front end two, open loop then chopped
    {diff_to_single_comparator_on, peak_enable, error_converter_mode, peak_front_end_choice} <= 7'h76;
    {frame_start_ramp_trigger, use_model} <= 5'h1F;
    count_a(0, cnt_open, cnt_b);
    chk(16'(cnt_open), 16'(2 * int'(event2[11:0])));
    chk(16'(cnt_b), 16'(2 * (int'(period_len) + 1 - int'(event3[11:0]))));
    @(posedge clk_sys);
    analog_peak_on <= 4'hF;
    count_a(0, cnt_chop, cnt_b);
    chk({15'h0000, cnt_chop < cnt_open}, 16'h0001);
    gap_b(cnt_chop);
    chk(16'(cnt_chop), 16'(int'(event3[11:0]) - int'(event2[11:0])));
    @(posedge clk_sys);
    ext_slope_comp <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // Two half-cycle starts per period, two periods counted
    count_a(1, cnt_open, cnt_b);
    chk(16'(cnt_open), 16'h0004);
    chk(16'(cnt_b), 16'h0004);
    @(posedge clk_sys);
    {ext_slope_comp, voltage_mode} <= 2'b01;
    // Let a full period pass so the count sees only voltage mode edges
    repeat (44) @(posedge clk_sys);
    count_a(0, cnt_open, cnt_b);
    chk(16'(cnt_open), 16'(2 * int'(filter_edge)));
    $display("chop test done");
    finish_test();
  end
endmodule : pcm_chain_tb
